// ===== rtl/ipe_cfg.svh
// constants of the two-wire protocol engine
`ifndef IPE_CFG_SVH
`define IPE_CFG_SVH
`define IPE_CLK_NS 10
`define IPE_T_SU_DAT_NS 250
`define IPE_T_HD_DAT_NS 300
`define IPE_T_HD_STA_NS 4000
`define IPE_T_SU_STO_NS 4000
`define IPE_T_HALF_NS 5000
`define IPE_SU_DAT_CYC ((`IPE_T_SU_DAT_NS + `IPE_CLK_NS - 1) / `IPE_CLK_NS)
`define IPE_HD_DAT_CYC ((`IPE_T_HD_DAT_NS + `IPE_CLK_NS - 1) / `IPE_CLK_NS)
`define IPE_HD_STA_CYC ((`IPE_T_HD_STA_NS + `IPE_CLK_NS - 1) / `IPE_CLK_NS)
`define IPE_SU_STO_CYC ((`IPE_T_SU_STO_NS + `IPE_CLK_NS - 1) / `IPE_CLK_NS)
`define IPE_HALF_CYC ((`IPE_T_HALF_NS + `IPE_CLK_NS - 1) / `IPE_CLK_NS)
`define IPE_TEN_BIT_HDR 5'h1E
`define IPE_ACK_SLOT 4'h8
`define IPE_LAST_SLOT 4'h9
`endif

// ===== rtl/ipe_pkg.sv
// state types of the two-wire protocol engine
package ipe_pkg;
   typedef enum logic [2:0] {
      sl_idle, sl_addr1, sl_addr2, sl_rx, sl_tx, sl_ignore
   } ipe_slave_st_t;
   typedef enum logic [2:0] {
      m_idle, m_hold, m_low, m_high, m_wait, m_stop_a, m_stop_b
   } ipe_mst_st_t;
endpackage

// ===== rtl/ipe_protocol_engine.sv
// two-wire serial controller protocol engine: slave, master, stretching
`timescale 1ns/1ns
`include "ipe_cfg.svh"
module ipe_protocol_engine (
   // system clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // link clock for the pad stage
   input wire logic link_clk,
   // bus pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // control
   input wire logic two_wire_mode_bit,
   input wire logic ten_bit_addr_select,
   input wire logic [9:0] own_slave_address,
   input wire logic addressed_irq_enable,
   input wire logic arb_lost_irq_enable,
   input wire logic ack_generate_bit,
   input wire logic start_generate_bit,
   input wire logic stop_generate_bit,
   // transmit buffer write and status read strobes
   input wire logic tx_write,
   input wire logic [7:0] tx_data,
   input wire logic status_read,
   // status
   output logic addressed_as_slave_flag,
   output logic arb_lost_flag,
   output logic stretch_active_flag,
   output logic bus_busy_flag,
   output logic addressed_irq,
   output logic arb_lost_irq,
   output logic [7:0] rx_data
);
   import ipe_pkg::*;

   logic l_rst1, l_rst2, l_scl1, l_scl2, l_sda1, l_sda2, l_dscl1, l_dsda1;
   logic c_scl1, c_scl2, c_sda1, c_sda2, scl_p, sda_p;
   logic drv_scl_low, drv_sda_low;
   logic [3:0] bit_cnt;
   logic [7:0] shift, tx_buf, tx_sh, m_byte;
   logic ack_seen, sl_ack, sl_prev, hit_pend, data_pend, arb_pend, arb_event;
   logic sl_sda_low, stretch, rel_busy;
   logic [11:0] rel_cnt, m_cnt;
   logic m_scl_low, m_sda_low, m_read, m_first;
   ipe_slave_st_t sl_state;
   ipe_mst_st_t m_state;
   logic scl_rise, start_det, stop_det, byte_full, byte_end, m_writing;

   // reset carried into the link domain, first flop feeds only the second
   always_ff @(posedge link_clk) begin
      l_rst1 <= srst;
      l_rst2 <= l_rst1;
   end

   // pad stage on the link clock: input samplers and drive enables
   always_ff @(posedge link_clk) begin
      l_scl1 <= scl_in;
      l_scl2 <= l_scl1;
      l_sda1 <= sda_in;
      l_sda2 <= l_sda1;
   end

   always_ff @(posedge link_clk) begin
      if (l_rst2) begin
         l_dscl1 <= 1'b0;
         l_dsda1 <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         l_dscl1 <= drv_scl_low;
         l_dsda1 <= drv_sda_low;
         scl_oe <= l_dscl1; // open drain: only ever pulls low
         sda_oe <= l_dsda1;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // line levels brought into the core domain
   always_ff @(posedge core_clk) begin
      if (srst) begin
         c_scl1 <= 1'b1;
         c_scl2 <= 1'b1;
         c_sda1 <= 1'b1;
         c_sda2 <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         c_scl1 <= l_scl2;
         c_scl2 <= c_scl1;
         c_sda1 <= l_sda2;
         c_sda2 <= c_sda1;
         scl_p <= c_scl2;
         sda_p <= c_sda2;
      end
   end

   // edge and condition detection; data edge while clock high
   assign scl_rise = c_scl2 & ~scl_p;
   assign start_det = two_wire_mode_bit & c_scl2 & scl_p & sda_p & ~c_sda2;
   assign stop_det = two_wire_mode_bit & c_scl2 & scl_p & ~sda_p & c_sda2;
   assign byte_full = ~c_scl2 & scl_p & (bit_cnt == `IPE_ACK_SLOT);
   assign byte_end = ~c_scl2 & scl_p & (bit_cnt == `IPE_LAST_SLOT);
   assign m_writing = ~m_read | m_first;

   // bit counter, receive shifter, acknowledge sampling
   always_ff @(posedge core_clk) begin
      if (srst || !two_wire_mode_bit) begin
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         ack_seen <= 1'b0;
      end else if (start_det) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise) begin
         if (bit_cnt < `IPE_ACK_SLOT)
            shift <= {shift[6:0], c_sda2};
         else if (bit_cnt == `IPE_ACK_SLOT)
            ack_seen <= ~c_sda2;
         if (bit_cnt != `IPE_LAST_SLOT)
            bit_cnt <= bit_cnt + 4'h1;
      end else if (byte_end) begin
         bit_cnt <= 4'h0;
      end
   end

   // bus busy between start and stop
   always_ff @(posedge core_clk) begin
      if (srst || !two_wire_mode_bit)
         bus_busy_flag <= 1'b0;
      else if (start_det)
         bus_busy_flag <= 1'b1;
      else if (stop_det)
         bus_busy_flag <= 1'b0;
   end

   // slave address comparison and data phase sequencing
   always_ff @(posedge core_clk) begin
      if (srst || !two_wire_mode_bit) begin
         sl_state <= sl_idle;
         sl_ack <= 1'b0;
         sl_prev <= 1'b0;
         hit_pend <= 1'b0;
         data_pend <= 1'b0;
      end else if (stop_det) begin
         sl_state <= sl_idle;
         sl_ack <= 1'b0;
         sl_prev <= 1'b0; // a stop ends the ten-bit addressed state
         hit_pend <= 1'b0;
         data_pend <= 1'b0;
      end else if (start_det) begin
         sl_state <= sl_addr1;
         sl_ack <= 1'b0;
      end else if (byte_full) begin
         case (sl_state)
            sl_addr1: begin
               if (!ten_bit_addr_select) begin
                  if (shift[7:1] == own_slave_address[6:0]) begin
                     sl_ack <= 1'b1;
                     hit_pend <= 1'b1;
                     sl_state <= shift[0] ? sl_tx : sl_rx;
                  end else
                     sl_state <= sl_ignore;
               end else if (shift[7:1] == {`IPE_TEN_BIT_HDR, own_slave_address[9:8]}) begin
                  if (!shift[0]) begin
                     sl_ack <= 1'b1;
                     sl_state <= sl_addr2;
                  end else if (sl_prev) begin
                     sl_ack <= 1'b1;
                     hit_pend <= 1'b1;
                     sl_state <= sl_tx;
                  end else
                     sl_state <= sl_ignore;
               end else
                  sl_state <= sl_ignore;
            end
            sl_addr2: begin
               if (shift == own_slave_address[7:0]) begin
                  sl_ack <= 1'b1;
                  hit_pend <= 1'b1;
                  sl_prev <= 1'b1;
                  sl_state <= sl_rx;
               end else
                  sl_state <= sl_ignore;
            end
            sl_rx: begin
               sl_ack <= 1'b1;
               data_pend <= 1'b1;
            end
            sl_tx: begin
               sl_ack <= 1'b0; // transmitter leaves the ack slot to the master
               data_pend <= 1'b1;
            end
            default: sl_ack <= 1'b0;
         endcase
      end else if (byte_end) begin
         sl_ack <= 1'b0;
         hit_pend <= 1'b0;
         data_pend <= 1'b0;
         if (sl_state == sl_tx && data_pend && !ack_seen)
            sl_state <= sl_ignore; // master declined further bytes
      end
   end

   // slave data line: changes only while the clock is low
   always_ff @(posedge core_clk) begin
      if (srst || !two_wire_mode_bit) begin
         sl_sda_low <= 1'b0;
         tx_sh <= 8'h00;
      end else begin
         if (byte_end && sl_state == sl_tx)
            tx_sh <= tx_buf;
         if (!c_scl2) begin
            if (bit_cnt == `IPE_ACK_SLOT)
               sl_sda_low <= sl_ack;
            else if (sl_state == sl_tx && bit_cnt < `IPE_ACK_SLOT)
               sl_sda_low <= ~tx_sh[3'(4'h7 - bit_cnt)];
            else
               sl_sda_low <= 1'b0;
         end
      end
   end

   // transmit buffer and received byte
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_buf <= 8'h00;
         rx_data <= 8'h00;
      end else begin
         if (tx_write)
            tx_buf <= tx_data;
         if (byte_full && (sl_state == sl_rx || (m_state != m_idle && !m_writing)))
            rx_data <= shift;
      end
   end

   // clock stretch: set at byte end, released setup time after a write
   always_ff @(posedge core_clk) begin
      if (srst || !two_wire_mode_bit) begin
         stretch <= 1'b0;
         rel_busy <= 1'b0;
         rel_cnt <= 12'h000;
      end else begin
         if (tx_write && stretch) begin
            rel_busy <= 1'b1;
            rel_cnt <= 12'h000;
         end else if (rel_busy) begin
            rel_cnt <= rel_cnt + 12'h001;
            if (rel_cnt == 12'(`IPE_SU_DAT_CYC - 1))
               rel_busy <= 1'b0;
         end
         if (byte_end && ((hit_pend && addressed_irq_enable) || data_pend || arb_pend))
            stretch <= 1'b1;
         else if (rel_busy && rel_cnt == 12'(`IPE_SU_DAT_CYC - 1))
            stretch <= 1'b0;
      end
   end

   // stretch status mirrors the held clock
   always_ff @(posedge core_clk) begin
      if (srst)
         stretch_active_flag <= 1'b0;
      else
         stretch_active_flag <= stretch;
   end

   // addressed flag and interrupt; a set beats a same-cycle clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         addressed_as_slave_flag <= 1'b0;
         addressed_irq <= 1'b0;
      end else if (byte_end && hit_pend) begin
         addressed_as_slave_flag <= 1'b1;
         addressed_irq <= addressed_irq_enable | addressed_irq;
      end else if (tx_write) begin
         addressed_as_slave_flag <= 1'b0;
         addressed_irq <= 1'b0;
      end
   end

   // arbitration flag immediately, interrupt after the byte
   always_ff @(posedge core_clk) begin
      if (srst) begin
         arb_lost_flag <= 1'b0;
         arb_lost_irq <= 1'b0;
         arb_pend <= 1'b0;
      end else begin
         if (arb_event)
            arb_lost_flag <= 1'b1;
         else if (status_read)
            arb_lost_flag <= 1'b0;
         if (byte_end && arb_pend && arb_lost_irq_enable)
            arb_lost_irq <= 1'b1;
         else if (status_read)
            arb_lost_irq <= 1'b0;
         if (arb_event)
            arb_pend <= 1'b1;
         else if (byte_end || stop_det)
            arb_pend <= 1'b0;
      end
   end

   // master: start, byte clocking, arbitration, stop
   always_ff @(posedge core_clk) begin
      if (srst || !two_wire_mode_bit) begin
         m_state <= m_idle;
         m_cnt <= 12'h000;
         m_scl_low <= 1'b0;
         m_sda_low <= 1'b0;
         m_byte <= 8'h00;
         m_read <= 1'b0;
         m_first <= 1'b0;
         arb_event <= 1'b0;
      end else begin
         arb_event <= 1'b0;
         m_cnt <= m_cnt + 12'h001;
         case (m_state)
            m_idle: begin
               m_scl_low <= 1'b0;
               m_sda_low <= 1'b0;
               if (start_generate_bit) begin
                  if (bus_busy_flag)
                     arb_event <= 1'b1;
                  else begin
                     m_sda_low <= 1'b1;
                     m_byte <= tx_buf;
                     m_first <= 1'b1;
                     m_read <= 1'b0;
                     m_cnt <= 12'h000;
                     m_state <= m_hold;
                  end
               end
            end
            m_hold: begin
               if (m_cnt == 12'(`IPE_HD_STA_CYC - 1)) begin
                  m_scl_low <= 1'b1;
                  m_cnt <= 12'h000;
                  m_state <= m_low;
               end
            end
            m_low: begin
               // data changes a hold time after the falling clock
               if (m_cnt == 12'(`IPE_HD_DAT_CYC)) begin
                  if (bit_cnt == `IPE_ACK_SLOT)
                     m_sda_low <= ~m_writing & ack_generate_bit;
                  else
                     m_sda_low <= m_writing & ~m_byte[3'(4'h7 - bit_cnt)];
               end
               if (m_cnt == 12'(`IPE_HALF_CYC - 1)) begin
                  m_scl_low <= 1'b0;
                  m_cnt <= 12'h000;
                  m_state <= m_high;
               end
            end
            m_high: begin
               // count the high phase only once the line is really high
               if (!c_scl2)
                  m_cnt <= 12'h000;
               if (scl_rise && bit_cnt < `IPE_ACK_SLOT && m_writing && !m_sda_low
                   && !c_sda2) begin
                  arb_event <= 1'b1;
                  m_scl_low <= 1'b0;
                  m_sda_low <= 1'b0;
                  m_state <= m_idle;
               end else if (c_scl2 && m_cnt == 12'(`IPE_HALF_CYC - 1)) begin
                  m_scl_low <= 1'b1;
                  m_cnt <= 12'h000;
                  if (bit_cnt != `IPE_LAST_SLOT)
                     m_state <= m_low;
                  else begin
                     m_first <= 1'b0;
                     if (m_first)
                        m_read <= m_byte[0];
                     m_state <= (m_writing && !ack_seen) ? m_stop_a : m_wait;
                  end
               end
            end
            m_wait: begin
               m_cnt <= 12'h000;
               if (stop_generate_bit)
                  m_state <= m_stop_a;
               else if (tx_write) begin
                  m_byte <= tx_data;
                  m_state <= m_low;
               end
            end
            m_stop_a: begin
               m_sda_low <= 1'b1;
               if (m_cnt == 12'(`IPE_SU_DAT_CYC - 1)) begin
                  m_scl_low <= 1'b0;
                  m_cnt <= 12'h000;
                  m_state <= m_stop_b;
               end
            end
            m_stop_b: begin
               if (!c_scl2)
                  m_cnt <= 12'h000;
               else if (m_cnt == 12'(`IPE_SU_STO_CYC - 1)) begin
                  m_sda_low <= 1'b0;
                  m_state <= m_idle;
               end
            end
            default: m_state <= m_idle;
         endcase
      end
   end

   // combined line drive handed to the pad stage
   always_ff @(posedge core_clk) begin
      if (srst) begin
         drv_scl_low <= 1'b0;
         drv_sda_low <= 1'b0;
      end else begin
         drv_scl_low <= m_scl_low | stretch;
         drv_sda_low <= m_sda_low | sl_sda_low;
      end
   end

endmodule

// ===== testbench/ipe_pe_checker.sv
// port assertions for the two-wire protocol engine
`timescale 1ns/1ns
module ipe_pe_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // pins
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   // control and strobes
   input wire logic two_wire_mode_bit,
   input wire logic addressed_irq_enable,
   input wire logic start_generate_bit,
   input wire logic tx_write,
   input wire logic status_read,
   // status
   input wire logic addressed_as_slave_flag,
   input wire logic arb_lost_flag,
   input wire logic stretch_active_flag,
   input wire logic bus_busy_flag,
   input wire logic addressed_irq,
   input wire logic arb_lost_irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [7:0] off_cnt;
   logic [7:0] since_wr;
   logic [7:0] hold_cnt;
   // cycles with the mode bit low, saturating
   always_ff @(posedge core_clk) begin
      if (srst || two_wire_mode_bit) off_cnt <= 8'h00;
      else if (off_cnt != 8'hFF) off_cnt <= off_cnt + 8'h01;
   end
   // cycles since the last buffer write, saturating
   always_ff @(posedge core_clk) begin
      if (srst || tx_write) since_wr <= 8'h00;
      else if (since_wr != 8'hFF) since_wr <= since_wr + 8'h01;
   end
   // age of the current stretch; pin path lags the flag by a link sync
   always_ff @(posedge core_clk) begin
      if (srst || !stretch_active_flag) hold_cnt <= 8'h00;
      else if (hold_cnt != 8'hFF) hold_cnt <= hold_cnt + 8'h01;
   end
   AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   AST_MODE_OFF: assert property (off_cnt > 8'h3C |->
      !scl_oe && !sda_oe && !addressed_as_slave_flag && !stretch_active_flag)
      else $error("engine active with mode off");
   AST_ADDR_CLR: assert property (tx_write |=> !addressed_as_slave_flag && !addressed_irq)
      else $error("addressed flag not cleared by write");
   AST_IRQ_CAUSE: assert property ($rose(addressed_irq) |->
      addressed_as_slave_flag && addressed_irq_enable)
      else $error("addressed irq without flag or enable");
   AST_STRETCH_REL: assert property (tx_write && stretch_active_flag |=>
      stretch_active_flag[*8] ##[14:20] !stretch_active_flag)
      else $error("stretch release not after setup time");
   AST_STRETCH_HOLD: assert property (stretch_active_flag && since_wr > 8'h28 &&
      two_wire_mode_bit |=> stretch_active_flag)
      else $error("stretch dropped without write");
   AST_STRETCH_PIN: assert property (hold_cnt > 8'h3C |-> scl_oe)
      else $error("stretch flag without clock held");
   AST_BUSY_LOST: assert property (start_generate_bit && bus_busy_flag |=>
      ##1 arb_lost_flag)
      else $error("start on busy bus not lost");
   AST_ARB_CLR: assert property (status_read &&
      !$past(start_generate_bit && bus_busy_flag) |=> !arb_lost_flag && !arb_lost_irq)
      else $error("status read left arbitration flag");
   AST_ARB_IRQ: assert property ($rose(arb_lost_irq) |-> arb_lost_flag)
      else $error("arbitration irq without flag");
   C_ADDR: cover property ($rose(addressed_as_slave_flag));
   C_ARB: cover property ($rose(arb_lost_irq));
   C_REL: cover property (tx_write && stretch_active_flag);
endmodule
bind ipe_protocol_engine ipe_pe_checker ipe_pe_checker_inst (.core_clk(core_clk),
   .srst(srst), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
   .two_wire_mode_bit(two_wire_mode_bit), .addressed_irq_enable(addressed_irq_enable),
   .start_generate_bit(start_generate_bit), .tx_write(tx_write), .status_read(status_read),
   .addressed_as_slave_flag(addressed_as_slave_flag), .arb_lost_flag(arb_lost_flag),
   .stretch_active_flag(stretch_active_flag), .bus_busy_flag(bus_busy_flag),
   .addressed_irq(addressed_irq), .arb_lost_irq(arb_lost_irq));

// ===== testbench/ipe_bus_master_model.sv
// behavioural remote bus master driving the engine as a slave
`timescale 1ns/1ns
module ipe_bus_master_model #(
   parameter int HALF = 100
) (
   // sampling clock
   input wire logic core_clk,
   // wire levels
   input wire logic scl,
   input wire logic sda,
   // open-drain pulls, high pulls the line low
   output logic scl_pull,
   output logic sda_pull
);
   int stalls;
   // lines released, clock stands still until a frame
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      stalls = 0;
   end
   // wait a number of system cycles
   task automatic gap(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // release clock, wait out a stretch, bounded so a stuck slave shows up
   task automatic scl_up();
      int n;
      n = 0;
      scl_pull = 1'b0;
      while (scl !== 1'b1 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 3000) stalls++;
   endtask
   // start or repeated start: data falls while clock is high
   task automatic start();
      gap(HALF / 4);
      sda_pull = 1'b0;
      gap(HALF);
      scl_up();
      gap(HALF);
      sda_pull = 1'b1;
      gap(HALF);
      scl_pull = 1'b1;
   endtask
   // one byte msb first, data moved only a quarter into the low phase
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         gap(HALF / 4);
         sda_pull = ~b[i];
         gap(HALF);
         scl_up();
         gap(HALF);
         scl_pull = 1'b1;
      end
      gap(HALF / 4);
      sda_pull = 1'b0;
      gap(HALF);
      scl_up();
      ack = (sda === 1'b0);
      gap(HALF);
      scl_pull = 1'b1;
      gap(HALF);
   endtask
   // stop: data rises while clock is high
   task automatic stop();
      gap(HALF / 4);
      sda_pull = 1'b1;
      gap(HALF);
      scl_up();
      gap(HALF);
      sda_pull = 1'b0;
      gap(HALF);
   endtask
endmodule

// ===== testbench/ipe_protocol_engine_tb.sv
// self-checking bench for the two-wire protocol engine
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module ipe_protocol_engine_tb;
   logic core_clk, link_clk, srst, scl_out, scl_oe, sda_out, sda_oe, scl_line, sda_line;
   logic two_wire_mode_bit, ten_bit_addr_select, addressed_irq_enable, arb_lost_irq_enable;
   logic ack_generate_bit, start_generate_bit, stop_generate_bit, tx_write, status_read;
   logic addressed_as_slave_flag, arb_lost_flag, stretch_active_flag, bus_busy_flag;
   logic addressed_irq, arb_lost_irq, m_scl_pull, m_sda_pull, ack;
   logic [9:0] own_slave_address;
   logic [7:0] tx_data, rx_data;
   int errors = 0;
   int checked = 0;
   // wired-and bus with pull-ups
   assign scl_line = ~((scl_oe & ~scl_out) | m_scl_pull);
   assign sda_line = ~((sda_oe & ~sda_out) | m_sda_pull);
   ipe_protocol_engine ipe_protocol_engine_inst (.core_clk(core_clk), .srst(srst),
      .link_clk(link_clk), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .two_wire_mode_bit(two_wire_mode_bit), .ten_bit_addr_select(ten_bit_addr_select),
      .own_slave_address(own_slave_address), .addressed_irq_enable(addressed_irq_enable),
      .arb_lost_irq_enable(arb_lost_irq_enable), .ack_generate_bit(ack_generate_bit),
      .start_generate_bit(start_generate_bit), .stop_generate_bit(stop_generate_bit),
      .tx_write(tx_write), .tx_data(tx_data), .status_read(status_read),
      .addressed_as_slave_flag(addressed_as_slave_flag), .arb_lost_flag(arb_lost_flag),
      .stretch_active_flag(stretch_active_flag), .bus_busy_flag(bus_busy_flag),
      .addressed_irq(addressed_irq), .arb_lost_irq(arb_lost_irq), .rx_data(rx_data));
   ipe_bus_master_model ipe_bus_master_model_inst (.core_clk(core_clk), .scl(scl_line),
      .sda(sda_line), .scl_pull(m_scl_pull), .sda_pull(m_sda_pull));
   // system clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // link clock, 125 ns, phase unrelated
   initial begin
      link_clk = 1'b0;
      #3;
      forever begin
         #62 link_clk = ~link_clk;
         #63 link_clk = ~link_clk;
      end
   end
   // one-cycle strobe on a control input
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic bus_byte(input logic [7:0] b);
      ipe_bus_master_model_inst.send_byte(b, ack);
   endtask
   task automatic buf_write(input logic [7:0] d);
      tx_data = d;
      pulse(tx_write);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // mode bit low: a matching address must go unanswered
   task automatic t_mode_off();
      two_wire_mode_bit = 1'b0;
      ipe_bus_master_model_inst.start();
      bus_byte(8'hB4);
      `CHK({ack, addressed_as_slave_flag}, 2'h0)
      ipe_bus_master_model_inst.stop();
      two_wire_mode_bit = 1'b1;
      cyc(50);
      `CHK({scl_oe, sda_oe, bus_busy_flag, stretch_active_flag}, 4'h0)
      $display("test mode_off done");
   endtask
   // seven-bit write: ack, flag, stretch, timed release, data byte
   task automatic t_seven();
      addressed_irq_enable = 1'b1;
      ipe_bus_master_model_inst.start();
      `CHK(bus_busy_flag, 1'b1)
      bus_byte(8'hB4);
      `CHK(ack, 1'b1)
      `CHK({addressed_as_slave_flag, addressed_irq, stretch_active_flag, scl_oe}, 4'hF)
      buf_write(8'h00);
      cyc(19);
      `CHK(stretch_active_flag, 1'b1)
      cyc(10);
      `CHK(stretch_active_flag, 1'b0)
      `CHK({addressed_as_slave_flag, addressed_irq}, 2'h0)
      bus_byte(8'hC3);
      `CHK(ack, 1'b1)
      `CHK(rx_data, 8'hC3)
      `CHK(stretch_active_flag, 1'b1)
      buf_write(8'h00);
      ipe_bus_master_model_inst.stop();
      cyc(50);
      `CHK(bus_busy_flag, 1'b0)
      $display("test seven_bit done");
   endtask
   // wrong address, then the right one which must still be ignored
   task automatic t_mismatch();
      ipe_bus_master_model_inst.start();
      bus_byte(8'h66);
      `CHK(ack, 1'b0)
      bus_byte(8'hB4);
      `CHK({ack, addressed_as_slave_flag}, 2'h0)
      ipe_bus_master_model_inst.stop();
      $display("test mismatch done");
   endtask
   // ten-bit write, repeated start read, then read without prior write
   task automatic t_ten();
      ten_bit_addr_select = 1'b1;
      addressed_irq_enable = 1'b0;
      own_slave_address = 10'h2A5;
      ipe_bus_master_model_inst.start();
      bus_byte(8'hF4);
      `CHK({ack, addressed_as_slave_flag}, 2'h2)
      bus_byte(8'hA5);
      `CHK(ack, 1'b1)
      `CHK({addressed_as_slave_flag, addressed_irq, stretch_active_flag}, 3'h4)
      buf_write(8'hFF);
      ipe_bus_master_model_inst.start();
      bus_byte(8'hF5);
      `CHK({ack, addressed_as_slave_flag}, 2'h3)
      ipe_bus_master_model_inst.stop();
      ipe_bus_master_model_inst.start();
      bus_byte(8'hF5);
      `CHK(ack, 1'b0)
      ipe_bus_master_model_inst.stop();
      ten_bit_addr_select = 1'b0;
      own_slave_address = 10'h05A;
      $display("test ten_bit done");
   endtask
   // start request on a busy bus: lost, irq and stretch at byte end
   task automatic t_arb();
      arb_lost_irq_enable = 1'b1;
      ipe_bus_master_model_inst.start();
      pulse(start_generate_bit);
      cyc(1);
      `CHK(arb_lost_flag, 1'b1)
      bus_byte(8'h66);
      `CHK({arb_lost_flag, arb_lost_irq, stretch_active_flag}, 3'h7)
      pulse(status_read);
      `CHK({arb_lost_flag, arb_lost_irq, stretch_active_flag}, 3'h1)
      buf_write(8'hFF);
      ipe_bus_master_model_inst.stop();
      cyc(50);
      `CHK(bus_busy_flag, 1'b0)
      $display("test arbitration done");
   endtask
   // master reads its own slave side, last byte left unacknowledged
   task automatic t_master();
      buf_write(8'hB5);
      pulse(start_generate_bit);
      cyc(10500);
      `CHK({addressed_as_slave_flag, scl_oe}, 2'h3)
      ack_generate_bit = 1'b0;
      buf_write(8'h00);
      cyc(10000);
      `CHK(rx_data, 8'hB5)
      `CHK(stretch_active_flag, 1'b1)
      pulse(stop_generate_bit);
      buf_write(8'h00);
      cyc(700);
      `CHK({bus_busy_flag, scl_oe, sda_oe}, 3'h0)
      $display("test master done");
   endtask
   // reset held over several link clocks, then the scenarios
   initial begin
      srst = 1'b1;
      two_wire_mode_bit = 1'b1;
      ten_bit_addr_select = 1'b0;
      own_slave_address = 10'h05A;
      addressed_irq_enable = 1'b0;
      arb_lost_irq_enable = 1'b0;
      ack_generate_bit = 1'b1;
      start_generate_bit = 1'b0;
      stop_generate_bit = 1'b0;
      tx_write = 1'b0;
      tx_data = 8'h00;
      status_read = 1'b0;
      repeat (6) @(posedge link_clk);
      cyc(6);
      srst = 1'b0;
      cyc(100);
      t_mode_off();
      t_seven();
      t_mismatch();
      t_ten();
      t_arb();
      t_master();
      `CHK(ipe_bus_master_model_inst.stalls, 0)
      end_sim();
   end
   // watchdog well past the expected run length
   initial begin
      repeat (95000) @(posedge core_clk);
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      end_sim();
   end
endmodule
